/* rtl/cprd_defs.vh */
// constants for the cursor power readout driver
`ifndef CPRD_DEFS_VH
`define CPRD_DEFS_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define CPRD_CLK_MHZ 40
// dark time between two digits (least time, rounds up)
`define CPRD_GAP_NS 2000
`define CPRD_GAP_CYC ((`CPRD_GAP_NS * `CPRD_CLK_MHZ + 999) / 1000)
// converter strobe silent this long means it stopped scanning
`define CPRD_STALL_US 2000
`define CPRD_STALL_CYC (`CPRD_STALL_US * `CPRD_CLK_MHZ)
// dwell per digit of the fallback scan
`define CPRD_STEP_US 500
`define CPRD_STEP_CYC (`CPRD_STEP_US * `CPRD_CLK_MHZ)

// ----------------------------------------------------------------
// channel geometry and scaling
// ----------------------------------------------------------------
// digit count includes the leading half digit (only 0 or 1)
`define CPRD_A_DIGITS 4
`define CPRD_B_DIGITS 5
`define CPRD_MAX_DIGITS 5
// weight of one converter count, in microvolts
`define CPRD_A_COUNT_UV 10000
`define CPRD_B_COUNT_UV 1000
// detector path scale, microvolts per dB
`define CPRD_LOG_UV_PER_DB 100000
// digits right of the decimal point follow from counts per dB
`define CPRD_DP_POS(uv) (((`CPRD_LOG_UV_PER_DB / (uv)) == 100) ? 2 : \
  (((`CPRD_LOG_UV_PER_DB / (uv)) == 10) ? 1 : 0))

// ----------------------------------------------------------------
// synchroniser bundle field positions
// ----------------------------------------------------------------
`define CPRD_IN_W 20
`define CPRD_IN_CURSOR 0
`define CPRD_IN_SIGN_A 1
`define CPRD_IN_SIGN_B 2
`define CPRD_IN_BCD_A 3
`define CPRD_IN_BCD_B 7
`define CPRD_IN_SEL_A 11
`define CPRD_IN_SEL_B 15

`endif

/* rtl/cprd_seg_decode.v */
// bcd to seven-segment decoder with blanking
`timescale 1ns/10ps
`default_nettype none

module cprd_seg_decode (
  input wire [3:0] bcd,   // digit value
  input wire blank,       // force all segments dark
  output reg [6:0] seg    // segments g..a, high lights a segment
);

  // ----------------------------------------------------------------
  // pattern table
  // ----------------------------------------------------------------
  // codes above nine show dark rather than a misleading glyph
  always @* begin
    seg = 7'h00;
    if (!blank) begin
      case (bcd)
        4'h0: seg = 7'h3F;
        4'h1: seg = 7'h06;
        4'h2: seg = 7'h5B;
        4'h3: seg = 7'h4F;
        4'h4: seg = 7'h66;
        4'h5: seg = 7'h6D;
        4'h6: seg = 7'h7D;
        4'h7: seg = 7'h07;
        4'h8: seg = 7'h7F;
        4'h9: seg = 7'h6F;
        default: seg = 7'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

/* rtl/cprd_readout.v */
// two-channel cursor power readout multiplexer
`timescale 1ns/10ps
`default_nettype none
`include "cprd_defs.vh"

module cprd_readout #(
  parameter [23:0] STALL_CYC = `CPRD_STALL_CYC,
  parameter [23:0] STEP_CYC = `CPRD_STEP_CYC
) (
  input wire clk,              // 40 MHz clock
  input wire reset_n,          // async reset, active low
  input wire cursorPulse,      // cursor pulse pin, high while present
  input wire convSignA,        // channel A converter polarity, high = negative
  input wire convSignB,        // channel B converter polarity, high = negative
  input wire [3:0] convBcdA,   // channel A converter bcd digit
  input wire [3:0] convBcdB,   // channel B converter bcd digit
  input wire [3:0] convSelA,   // channel A digit strobes, bit 0 = least digit
  input wire [4:0] convSelB,   // channel B digit strobes, bit 0 = least digit
  output wire [6:0] segA,      // channel A segment lines g..a
  output wire [6:0] segB,      // channel B segment lines g..a
  output wire [3:0] anodeA,    // channel A digit anodes, high enables
  output wire [4:0] anodeB,    // channel B digit anodes, high enables
  output wire dpA,             // channel A decimal point driver
  output wire dpB,             // channel B decimal point driver
  output wire minusA,          // channel A minus sign driver
  output wire minusB           // channel B minus sign driver
);

  localparam MAXD = `CPRD_MAX_DIGITS;
  localparam [23:0] GAP_CYC = `CPRD_GAP_CYC;

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  // every converter pin is asynchronous; a new level is taken only when
  // the second and third stages agree, which also rejects single glitches
  wire [`CPRD_IN_W-1:0] pinBus;
  reg [`CPRD_IN_W-1:0] syn1_q;
  reg [`CPRD_IN_W-1:0] syn2_q;
  reg [`CPRD_IN_W-1:0] syn3_q;
  reg [`CPRD_IN_W-1:0] inS_q;
  wire [`CPRD_IN_W-1:0] agree;

  assign pinBus = {convSelB, convSelA, convBcdB, convBcdA, convSignB, convSignA, cursorPulse};
  assign agree = ~(syn2_q ^ syn3_q);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syn1_q <= {`CPRD_IN_W{1'b0}};
      syn2_q <= {`CPRD_IN_W{1'b0}};
      syn3_q <= {`CPRD_IN_W{1'b0}};
      inS_q <= {`CPRD_IN_W{1'b0}};
    end else begin
      syn1_q <= pinBus;
      syn2_q <= syn1_q;
      syn3_q <= syn2_q;
      inS_q <= (syn3_q & agree) | (inS_q & ~agree);
    end
  end

  wire cursorS = inS_q[`CPRD_IN_CURSOR];
  wire [1:0] signS = {inS_q[`CPRD_IN_SIGN_B], inS_q[`CPRD_IN_SIGN_A]};
  wire [3:0] bcdS [0:1];
  wire [4:0] selS [0:1];
  assign bcdS[0] = inS_q[`CPRD_IN_BCD_A +: 4];
  assign bcdS[1] = inS_q[`CPRD_IN_BCD_B +: 4];
  assign selS[0] = {1'b0, inS_q[`CPRD_IN_SEL_A +: 4]};
  assign selS[1] = inS_q[`CPRD_IN_SEL_B +: 5];

  // one-hot strobe to index; valid only with exactly one bit set
  function [3:0] selDecode;
    input [4:0] sel;
    integer k;
    reg [2:0] cnt;
    reg [2:0] idx;
    begin
      cnt = 3'd0;
      idx = 3'd0;
      for (k = 0; k < MAXD; k = k + 1) begin
        if (sel[k]) begin
          cnt = cnt + 3'd1;
          idx = k[2:0];
        end
      end
      selDecode = {(cnt == 3'd1), idx};
    end
  endfunction

  wire [6:0] segW [0:1];
  wire [4:0] anodeW [0:1];
  wire [1:0] dpW;
  wire [1:0] minusW;

  // ----------------------------------------------------------------
  // channel paths, identical apart from digit count and point
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
      localparam NDIG = (ch == 0) ? `CPRD_A_DIGITS : `CPRD_B_DIGITS;
      localparam [2:0] DPPOS = (ch == 0) ? `CPRD_DP_POS(`CPRD_A_COUNT_UV) :
        `CPRD_DP_POS(`CPRD_B_COUNT_UV);
      localparam [2:0] TOPIDX = NDIG - 1;

      reg [4*MAXD-1:0] dig_q;
      reg sign_q;
      reg [2:0] selIdx_q;
      reg stalled_q;
      reg [23:0] stallCnt_q;
      reg [23:0] stepCnt_q;
      reg [2:0] scanIdx_q;
      reg [2:0] shownIdx_q;
      reg [23:0] gapCnt_q;
      reg [6:0] seg_q;
      reg [4:0] anode_q;
      reg dp_q;
      reg minus_q;
      reg [MAXD-1:0] blankVec;
      wire [3:0] selInfo;
      wire [2:0] showIdx;
      wire [6:0] segDec;
      wire gapNow;
      integer j;

      assign selInfo = selDecode(selS[ch]);

      // capture the strobed digit only while the cursor is present,
      // so the readout holds the power found under the cursor
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          dig_q <= {4*MAXD{1'b0}};
          sign_q <= 1'b0;
        end else if (cursorS) begin
          sign_q <= signS[ch];
          if (selInfo[3] && selInfo[2:0] <= TOPIDX) begin
            if (selInfo[2:0] == TOPIDX)
              dig_q[4*selInfo[2:0] +: 4] <= {3'b000, bcdS[ch][0]};
            else
              dig_q[4*selInfo[2:0] +: 4] <= bcdS[ch];
          end
        end
      end

      // leading zeros dark down to the digit left of the point
      always @* begin
        blankVec = {MAXD{1'b0}};
        for (j = MAXD - 1; j >= 0; j = j - 1) begin
          if (j < NDIG && j > DPPOS) begin
            if (j == NDIG - 1)
              blankVec[j] = (dig_q[4*j +: 4] == 4'h0);
            else
              blankVec[j] = blankVec[j + 1] && (dig_q[4*j +: 4] == 4'h0);
          end
        end
      end

      // strobe tracking with a fallback scan; if the converter strobes
      // stop, the block scans by itself so the panel never freezes on
      // one bright digit
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          selIdx_q <= 3'd0;
          stalled_q <= 1'b0;
          stallCnt_q <= 24'h00_0000;
          stepCnt_q <= 24'h00_0000;
          scanIdx_q <= 3'd0;
        end else begin
          if (selInfo[3] && selInfo[2:0] <= TOPIDX && selInfo[2:0] != selIdx_q) begin
            selIdx_q <= selInfo[2:0];
            stallCnt_q <= 24'h00_0000;
            stalled_q <= 1'b0;
          end else if (stallCnt_q == STALL_CYC - 24'h00_0001) begin
            stalled_q <= 1'b1;
          end else begin
            stallCnt_q <= stallCnt_q + 24'h00_0001;
          end
          if (stepCnt_q == STEP_CYC - 24'h00_0001) begin
            stepCnt_q <= 24'h00_0000;
            scanIdx_q <= (scanIdx_q == TOPIDX) ? 3'd0 : scanIdx_q + 3'd1;
          end else begin
            stepCnt_q <= stepCnt_q + 24'h00_0001;
          end
        end
      end

      assign showIdx = stalled_q ? scanIdx_q : selIdx_q;
      assign gapNow = (showIdx != shownIdx_q) || (gapCnt_q != 24'h00_0000);

      cprd_seg_decode uDec (
        .bcd(dig_q[4*showIdx +: 4]),
        .blank(blankVec[showIdx]),
        .seg(segDec)
      );

      // dark gap on every digit change keeps the old pattern from
      // ghosting onto the next digit
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          shownIdx_q <= 3'd0;
          gapCnt_q <= 24'h00_0000;
          seg_q <= 7'h00;
          anode_q <= 5'h00;
          dp_q <= 1'b0;
          minus_q <= 1'b0;
        end else begin
          if (showIdx != shownIdx_q) begin
            shownIdx_q <= showIdx;
            gapCnt_q <= GAP_CYC - 24'h00_0001;
          end else if (gapCnt_q != 24'h00_0000) begin
            gapCnt_q <= gapCnt_q - 24'h00_0001;
          end
          if (gapNow) begin
            anode_q <= 5'h00;
            seg_q <= 7'h00;
            dp_q <= 1'b0;
          end else begin
            anode_q <= 5'h01 << showIdx;
            seg_q <= segDec;
            dp_q <= (showIdx == DPPOS);
          end
          minus_q <= sign_q;
        end
      end

      assign segW[ch] = seg_q;
      assign anodeW[ch] = anode_q;
      assign dpW[ch] = dp_q;
      assign minusW[ch] = minus_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin mapping
  // ----------------------------------------------------------------
  wire [4:0] anodeAFull = anodeW[0];
  assign segA = segW[0];
  assign segB = segW[1];
  assign anodeA = anodeAFull[3:0];
  assign anodeB = anodeW[1];
  assign dpA = dpW[0];
  assign dpB = dpW[1];
  assign minusA = minusW[0];
  assign minusB = minusW[1];

endmodule

`default_nettype wire

/* bench/cprd_readout_asserts.sv */
// port checks for the cursor power readout driver
`timescale 1ns/10ps
`default_nettype none
module cprd_readout_chk (
  input wire logic clk, // 40 MHz clock
  input wire logic reset_n, // async reset, active low
  input wire logic cursorPulse, // cursor pin
  input wire logic [6:0] segA, // A segments
  input wire logic [3:0] anodeA, // A anodes
  input wire logic [4:0] anodeB, // B anodes
  input wire logic dpA, // A point
  input wire logic dpB, // B point
  input wire logic minusA // A sign
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // strobe and gap rules
  chk_one_anode_a: assert property ($onehot0(anodeA))
    else $error("several A anodes lit");
  chk_one_anode_b: assert property ($onehot0(anodeB))
    else $error("several B anodes lit");
  chk_dark_switch_a: assert property ($past(anodeA) != 4'h0 && anodeA != $past(anodeA) |-> anodeA == 4'h0)
    else $error("A anode jumped without gap");
  chk_dark_switch_b: assert property ($past(anodeB) != 5'h00 && anodeB != $past(anodeB) |-> anodeB == 5'h00)
    else $error("B anode jumped without gap");
  chk_gap_length_a: assert property (anodeA == 4'h0 && $past(anodeA) != 4'h0 |=> (anodeA == 4'h0) [*8])
    else $error("A gap too short");
  // point, blanking and sample-hold
  chk_point_a: assert property (dpA |-> anodeA == 4'h2)
    else $error("A point on wrong digit");
  chk_point_b: assert property (dpB |-> anodeB == 5'h04)
    else $error("B point on wrong digit");
  chk_ones_lit_a: assert property (anodeA[0] |-> segA != 7'h00)
    else $error("A units digit blanked");
  chk_sign_held: assert property ((!cursorPulse) [*8] |-> $stable(minusA))
    else $error("A sign moved outside cursor");
endmodule

bind cprd_readout cprd_readout_chk u_chk (.clk(clk), .reset_n(reset_n),
  .cursorPulse(cursorPulse), .segA(segA), .anodeA(anodeA), .anodeB(anodeB),
  .dpA(dpA), .dpB(dpB), .minusA(minusA));
`default_nettype wire

/* bench/cprd_conv_model.sv */
// converter model: walks one-hot digit strobes and shows that digit's bcd
`timescale 1ns/10ps
`default_nettype none
module cprd_conv_model #(
  parameter int N = 4,
  parameter int DWELL = 200
) (
  input wire logic clk, // system clock
  input wire logic run, // low freezes the scan
  input wire logic [4*N-1:0] value, // bcd digits, digit 0 lowest
  output logic [N-1:0] sel, // one-hot strobe
  output logic [3:0] bcd // digit under strobe
);
  int cnt = 0;
  int idx = 0;
  // steps off the sampling edge; a frozen scan exercises the fallback
  always @(negedge clk) begin
    if (run) begin
      cnt <= (cnt == DWELL - 1) ? 0 : cnt + 1;
      if (cnt == DWELL - 1) idx <= (idx == N - 1) ? 0 : idx + 1;
    end
  end
  assign sel = {{(N - 1){1'b0}}, 1'b1} << idx;
  assign bcd = value[4*idx +: 4];
endmodule
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the cursor power readout driver
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {logic ch, cur, sgn; logic [19:0] v; int i; logic [6:0] s; logic dp, mn;}
    cprd_row_t;
  logic clk = 1'b0;
  logic resetN = 1'b0;
  logic cursorPulse = 1'b0;
  logic convSignA = 1'b0;
  logic convSignB = 1'b0;
  logic runConv = 1'b1;
  logic [15:0] valA = 16'h0000;
  logic [19:0] valB = 20'h0_0000;
  logic [3:0] bcdA, bcdB, selA, anodeA;
  logic [4:0] selB, anodeB;
  logic [6:0] segA, segB;
  logic dpA, dpB, minusA, minusB;
  int errTotal = 0;
  int nChecks = 0;
  // channel, cursor, sign, value, digit, segments, point, minus
  cprd_row_t rows [13] = '{
    '{0, 1, 0, 20'h0_1234, 3, 7'h06, 0, 0}, '{0, 1, 1, 20'h0_1234, 2, 7'h5B, 0, 1},
    '{0, 1, 0, 20'h0_1234, 1, 7'h4F, 1, 0}, '{0, 1, 0, 20'h0_0005, 2, 7'h00, 0, 0},
    '{0, 1, 0, 20'h0_0005, 1, 7'h3F, 1, 0}, '{0, 1, 0, 20'h0_0005, 0, 7'h6D, 0, 0},
    '{0, 0, 1, 20'h0_0999, 0, 7'h6D, 0, 0}, '{1, 1, 1, 20'h0_9876, 3, 7'h6F, 0, 1},
    '{1, 1, 0, 20'h0_9876, 2, 7'h7F, 1, 0}, '{1, 1, 0, 20'h0_9876, 1, 7'h07, 0, 0},
    '{1, 1, 0, 20'h0_9876, 0, 7'h7D, 0, 0}, '{1, 1, 0, 20'h1_0004, 4, 7'h06, 0, 0},
    '{1, 0, 0, 20'h0_0000, 0, 7'h66, 0, 0}};

  cprd_readout #(.STALL_CYC(24'h00_07D0), .STEP_CYC(24'h00_0064)) dut (.clk(clk),
    .reset_n(resetN), .cursorPulse(cursorPulse), .convSignA(convSignA),
    .convSignB(convSignB), .convBcdA(bcdA), .convBcdB(bcdB), .convSelA(selA),
    .convSelB(selB), .segA(segA), .segB(segB), .anodeA(anodeA), .anodeB(anodeB),
    .dpA(dpA), .dpB(dpB), .minusA(minusA), .minusB(minusB));
  // both converters use the model's default dwell per digit
  cprd_conv_model #(.N(4)) convA (.clk(clk), .run(runConv), .value(valA),
    .sel(selA), .bcd(bcdA));
  cprd_conv_model #(.N(5)) convB (.clk(clk), .run(runConv), .value(valB),
    .sel(selB), .bcd(bcdB));

  initial forever #12.5 clk = ~clk;

  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for a strobe bit; a stuck converter ends the run
  task automatic waitSel(input logic ch, input int i, input logic lv);
    for (int k = 0; k < 3000; k++) begin
      if ((ch ? selB[i] : selA[i]) === lv) return;
      @(negedge clk);
    end
    chk(~lv, lv);
    reportAndStop;
  endtask

  // a whole scan passes first so upper digits are fresh for blanking
  task automatic runRow(input cprd_row_t r);
    cursorPulse = r.cur;
    if (r.ch) convSignB = r.sgn;
    else convSignA = r.sgn;
    if (r.ch) valB = r.v;
    else valA = r.v[15:0];
    repeat (1100) @(negedge clk);
    waitSel(r.ch, r.i, 1'b0);
    waitSel(r.ch, r.i, 1'b1);
    repeat (150) @(negedge clk);
    if (r.ch) chk({segB, dpB, minusB}, {r.s, r.dp, r.mn});
    else chk({segA, dpA, minusA}, {r.s, r.dp, r.mn});
    if (r.s != 7'h00) chk(r.ch ? anodeB : {1'b0, anodeA}, 5'h01 << r.i);
  endtask

  initial begin
    int k;
    repeat (16) @(negedge clk);
    chk({anodeA, anodeB, segA, segB}, 0);
    resetN = 1'b1;
    $display("reset test done");
    foreach (rows[n]) begin
      runRow(rows[n]);
      $display("row %0d done", n);
    end
    // converter stops: the fallback scan must light another digit
    runConv = 1'b0;
    repeat (3000) @(negedge clk);
    for (k = 0; k < 2000 && (anodeA === 4'h0 || anodeA === selA); k++) @(negedge clk);
    chk(k < 2000, 1);
    runConv = 1'b1;
    $display("stall test done");
    // reset in mid-run darkens everything at once
    resetN = 1'b0;
    repeat (2) @(negedge clk);
    chk({anodeA, anodeB, segA, segB, dpA, dpB, minusA, minusB}, 0);
    resetN = 1'b1;
    // two edges on, strobes are still in the synchroniser: digit 0 of a cleared store shows
    repeat (2) @(negedge clk);
    chk({anodeA, segA, dpA, minusA}, {4'h1, 7'h3F, 2'b00});
    $display("second reset done");
    reportAndStop;
  end
endmodule
`default_nettype wire
